// *** rtl/gpio_port.v ***
// Eight-pin bidirectional general-purpose port with weak pull-ups and
// interrupt-on-change on the upper four pins.
// Assumes a simple register port: one-cycle strobes, read data a cycle later.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "gpio_port_regs.vh"
module gpio_port #(
  parameter WIDTH = 8
) (
  // Clock and resets
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             por_n_in,
  // Configuration strap: 1 selects analog start-up of the low pins
  input  wire             analog_default_cfg_in,
  // Register port
  input  wire [3:0]       addr_in,
  input  wire [7:0]       wdata_in,
  input  wire             wr_in,
  input  wire             rd_in,
  input  wire             mem_to_mem_move_in,
  output reg  [7:0]       rdata_out,
  // Pins
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out,
  output wire [WIDTH-1:0] pin_oe_out,
  output wire [WIDTH-1:0] pullup_en_out,
  // Interrupt
  output wire             change_irq_out,
  output wire             wake_out
);
  // Strap sequencer states, one-hot
  localparam [1:0] ST_STRAP = 2'b01;
  localparam [1:0] ST_RUN   = 2'b10;

  // Registers and their next values
  reg  [WIDTH-1:0] latch_q;
  reg  [WIDTH-1:0] latch_d;
  reg  [WIDTH-1:0] dir_q;
  reg  [WIDTH-1:0] dir_d;
  reg  [WIDTH-1:0] pu_mask_q;
  reg  [WIDTH-1:0] pu_mask_d;
  reg  [3:0]       ioc_mask_q;
  reg  [3:0]       ioc_mask_d;
  reg              pu_dis_q;
  reg              pu_dis_d;
  reg              ioc_gen_q;
  reg              ioc_gen_d;
  reg              flag_q;
  reg              flag_d;
  reg  [4:0]       ansel_q;
  reg  [4:0]       ansel_d;
  reg  [1:0]       state_q;
  reg  [1:0]       state_d;
  reg  [7:0]       rdata_d;
  // Decoded selects, write enables, read fields and pin view
  wire             sel_pin_data;
  wire             sel_latch;
  wire             sel_dir;
  wire             sel_pu_mask;
  wire             sel_ioc_mask;
  wire             sel_ctrl_1;
  wire             sel_ctrl_2;
  wire             sel_ansel;
  wire             we_latch;
  wire             we_dir;
  wire             we_pu_mask;
  wire             we_ioc_mask;
  wire             we_ctrl_1;
  wire             we_ctrl_2;
  wire             we_ansel;
  wire [7:0]       ioc_mask_rd;
  wire [7:0]       ctrl_1_rd;
  wire [7:0]       ctrl_2_rd;
  wire [7:0]       ansel_rd;
  wire [WIDTH-1:0] pin_read;
  wire             mismatch;
  wire             port_access;
  wire             flag_clear;

  // Address decode; unmapped offsets select nothing, so writes there are dropped
  assign sel_pin_data = (addr_in == `ADDR_PORT_PIN_DATA);
  assign sel_latch    = (addr_in == `ADDR_PORT_OUTPUT_LATCH);
  assign sel_dir      = (addr_in == `ADDR_PORT_DIRECTION);
  assign sel_pu_mask  = (addr_in == `ADDR_PULLUP_ENABLE_MASK);
  assign sel_ioc_mask = (addr_in == `ADDR_CHANGE_IRQ_ENABLE);
  assign sel_ctrl_1   = (addr_in == `ADDR_INTERRUPT_CTRL_1);
  assign sel_ctrl_2   = (addr_in == `ADDR_INTERRUPT_CTRL_2);
  assign sel_ansel    = (addr_in == `ADDR_ANALOG_SELECT_HIGH);

  // Write enables, one per register
  assign we_latch    = wr_in & (sel_pin_data | sel_latch);
  assign we_dir      = wr_in & sel_dir;
  assign we_pu_mask  = wr_in & sel_pu_mask;
  assign we_ioc_mask = wr_in & sel_ioc_mask;
  assign we_ctrl_1   = wr_in & sel_ctrl_1;
  assign we_ctrl_2   = wr_in & sel_ctrl_2;
  assign we_ansel    = wr_in & sel_ansel;

  // Per-pin data path
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      // Direction 0 drives the latch out; direction 1 releases the pin
      assign pin_out[i]    = latch_q[i];
      assign pin_oe_out[i] = ~dir_q[i];
      if (i < `ANALOG_LOW_PINS) begin : g_ana
        // Analog-selected pins read as zero, whatever the pin does
        assign pin_read[i] = pin_in[i] & ~ansel_q[i];
      end else begin : g_dig
        assign pin_read[i] = pin_in[i];
      end
    end
  endgenerate

  // Move accesses reach the port without disturbing the snapshot
  assign port_access = (rd_in | wr_in) & sel_pin_data & ~mem_to_mem_move_in;
  assign flag_clear  = we_ctrl_1 & ~wdata_in[`BIT_CHANGE_IRQ_FLAG];

  // Pull-ups follow the registers combinationally
  pullup_ctrl #(
    .WIDTH (WIDTH)
  ) u_pullup (
    .mask_in       (pu_mask_q),
    .global_dis_in (pu_dis_q),
    .direction_in  (dir_q),
    .pullup_en_out (pullup_en_out)
  );

  // Change detector; its snapshot clears on power-on only
  change_detect #(
    .WIDTH (4)
  ) u_change (
    .clk_in       (clk_in),
    .por_n_in     (por_n_in),
    .pins_in      (pin_read[7:4]),
    .enable_in    (ioc_mask_q),
    .direction_in (dir_q[7:4]),
    .refresh_in   (port_access),
    .mismatch_out (mismatch)
  );

  // Two reset domains: every register below clears on the general reset
  // (power-on, master clear, brown-out), while the change snapshot only
  // clears on power-on, so a mismatch that outlives a master clear raises
  // the flag again once the change mask is written back.

  // Output latch: pin data and latch offsets both write it, so
  // read-modify-write on the latch never picks up pin levels
  always @* begin
    latch_d = latch_q;
    if (we_latch) begin
      latch_d = wdata_in;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_q <= `RST_LATCH;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Direction: reset leaves every pin an input
  always @* begin
    dir_d = dir_q;
    if (we_dir) begin
      dir_d = wdata_in;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_q <= `RST_DIRECTION;
    end else begin
      dir_q <= dir_d;
    end
  end

  // Pull-up mask
  always @* begin
    pu_mask_d = pu_mask_q;
    if (we_pu_mask) begin
      pu_mask_d = wdata_in;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pu_mask_q <= `RST_PULLUP_MASK;
    end else begin
      pu_mask_q <= pu_mask_d;
    end
  end

  // Change mask: only the upper four bits exist
  always @* begin
    ioc_mask_d = ioc_mask_q;
    if (we_ioc_mask) begin
      ioc_mask_d = wdata_in[7:`CHANGE_MASK_LSB];
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ioc_mask_q <= `RST_CHANGE_MASK;
    end else begin
      ioc_mask_q <= ioc_mask_d;
    end
  end

  // Global pull-up disable; set out of reset so pull-ups start off
  always @* begin
    pu_dis_d = pu_dis_q;
    if (we_ctrl_2) begin
      pu_dis_d = wdata_in[`BIT_PULLUP_GLOBAL_DIS];
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pu_dis_q <= `RST_PULLUP_GLOBAL_DIS;
    end else begin
      pu_dis_q <= pu_dis_d;
    end
  end

  // Global change enable
  always @* begin
    ioc_gen_d = ioc_gen_q;
    if (we_ctrl_1) begin
      ioc_gen_d = wdata_in[`BIT_CHANGE_IRQ_GLOBAL_EN];
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ioc_gen_q <= `RST_CHANGE_GLOBAL_EN;
    end else begin
      ioc_gen_q <= ioc_gen_d;
    end
  end

  // Strap sequencer: the strap is caught on the first edge after reset
  // release; an analog-select write in that same cycle is lost
  always @* begin
    state_d = state_q;
    ansel_d = ansel_q;
    case (state_q)
      ST_STRAP: begin
        ansel_d = analog_default_cfg_in ? `ANALOG_SELECT_ALL : `ANALOG_SELECT_NONE;
        state_d = ST_RUN;
      end
      ST_RUN: begin
        if (we_ansel) begin
          ansel_d = wdata_in[4:0];
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_STRAP;
      ansel_q <= `RST_ANALOG_SELECT;
    end else begin
      state_q <= state_d;
      ansel_q <= ansel_d;
    end
  end

  // Flag: a live mismatch sets it every cycle and wins over a clear,
  // so software must access the port before the clear can stick
  always @* begin
    flag_d = flag_q;
    if (mismatch) begin
      flag_d = 1'b1;
    end else if (flag_clear) begin
      flag_d = 1'b0;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_q <= `RST_CHANGE_FLAG;
    end else begin
      flag_q <= flag_d;
    end
  end

  // The request is a level, so it also serves as the wake-up from sleep
  assign change_irq_out = flag_q & ioc_gen_q;
  assign wake_out       = change_irq_out;

  always @* begin
    case (addr_in)
      `ADDR_PORT_PIN_DATA:      rdata_d = pin_read;
      `ADDR_PORT_OUTPUT_LATCH:  rdata_d = latch_q;
      `ADDR_PORT_DIRECTION:     rdata_d = dir_q;
      `ADDR_PULLUP_ENABLE_MASK: rdata_d = pu_mask_q;
      `ADDR_CHANGE_IRQ_ENABLE:  rdata_d = ioc_mask_rd;
      `ADDR_INTERRUPT_CTRL_1:   rdata_d = ctrl_1_rd;
      `ADDR_INTERRUPT_CTRL_2:   rdata_d = ctrl_2_rd;
      `ADDR_ANALOG_SELECT_HIGH: rdata_d = ansel_rd;
      default:                  rdata_d = 8'h00;
    endcase
  end

  // Read fields; unimplemented bits read as zero
  assign ioc_mask_rd = {ioc_mask_q, 4'h0};
  assign ctrl_1_rd   = {4'h0, ioc_gen_q, 2'b00, flag_q};
  assign ctrl_2_rd   = {pu_dis_q, 7'h00};
  assign ansel_rd    = {3'h0, ansel_q};

  // Read data stand for one cycle only and are zero otherwise
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= `RST_READ_DATA;
    end else if (rd_in) begin
      rdata_out <= rdata_d;
    end else begin
      rdata_out <= 8'h00;
    end
  end
endmodule

// *** rtl/gpio_port_regs.vh ***
// Register offsets, field positions and reset values for the 8-bit GPIO port.
// Included by the port core only; the helpers do not use it; definitions only.
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

`define ADDR_PORT_PIN_DATA       4'h0
`define ADDR_PORT_OUTPUT_LATCH   4'h1
`define ADDR_PORT_DIRECTION      4'h2
`define ADDR_PULLUP_ENABLE_MASK  4'h3
`define ADDR_CHANGE_IRQ_ENABLE   4'h4
`define ADDR_INTERRUPT_CTRL_1    4'h5
`define ADDR_INTERRUPT_CTRL_2    4'h6
`define ADDR_ANALOG_SELECT_HIGH  4'h7

`define BIT_CHANGE_IRQ_FLAG      0
`define BIT_CHANGE_IRQ_GLOBAL_EN 3
`define BIT_PULLUP_GLOBAL_DIS    7

`define RST_DIRECTION            8'hff
`define RST_LATCH                8'h00
`define RST_PULLUP_MASK          8'h00
`define RST_CHANGE_MASK          4'h0
`define RST_PULLUP_GLOBAL_DIS    1'b1
`define RST_CHANGE_GLOBAL_EN     1'b0
`define RST_CHANGE_FLAG          1'b0
`define RST_ANALOG_SELECT        5'h1f
`define RST_READ_DATA            8'h00
`define ANALOG_LOW_MASK          8'h1f
`define ANALOG_LOW_PINS          5
`define ANALOG_SELECT_ALL        5'h1f
`define ANALOG_SELECT_NONE       5'h00
`define CHANGE_MASK_LSB          4

`endif

// *** rtl/pullup_ctrl.v ***
// Per-pin weak pull-up enable logic for the 8-bit port.
// Assumes direction bit 1 means input; all inputs come from registers.
`timescale 1ns/1ps
module pullup_ctrl #(
  parameter WIDTH = 8
) (
  // Configuration
  input  wire [WIDTH-1:0] mask_in,
  input  wire             global_dis_in,
  input  wire [WIDTH-1:0] direction_in,
  // Pull-up drive
  output wire [WIDTH-1:0] pullup_en_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pu
      // Outputs never get a pull-up, whatever the mask says
      assign pullup_en_out[i] = mask_in[i] & ~global_dis_in & direction_in[i];
    end
  endgenerate
endmodule

// *** rtl/change_detect.v ***
// Interrupt-on-change mismatch detector for the upper port pins.
// The snapshot sits on its own power-on reset so that master-clear and
// brown-out resets leave it alone.
`timescale 1ns/1ps
module change_detect #(
  parameter WIDTH = 4
) (
  // Clock and power-on reset
  input  wire             clk_in,
  input  wire             por_n_in,
  // Pin state and configuration
  input  wire [WIDTH-1:0] pins_in,
  input  wire [WIDTH-1:0] enable_in,
  input  wire [WIDTH-1:0] direction_in,
  input  wire             refresh_in,
  // Result
  output wire             mismatch_out
);
  reg  [WIDTH-1:0] snapshot_q;
  wire [WIDTH-1:0] diff;

  always @(posedge clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      snapshot_q <= {WIDTH{1'b0}};
    end else if (refresh_in) begin
      snapshot_q <= pins_in;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_cmp
      assign diff[i] = enable_in[i] & direction_in[i] & (pins_in[i] ^ snapshot_q[i]);
    end
  endgenerate

  assign mismatch_out = |diff;
endmodule

// *** test/gpio_port_props.sv ***
// Checker for the GPIO port: register effects, read data, pull-ups and change interrupt.
// Sees only the port's own pins; bound into every gpio_port instance.
`timescale 1ns/1ps
module gpio_port_props (
  input wire       clk_in,
  input wire       rst_n_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire [7:0] pin_in,
  input wire [7:0] rdata_out,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe_out,
  input wire [7:0] pullup_en_out,
  input wire       change_irq_out,
  input wire       wake_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_pu_out; (pullup_en_out & pin_oe_out) == 8'h00; endproperty
  a_pu_out: assert property (p_pu_out) else $error("pull-up on a driven pin");
  property p_pu_mask; wr_in && addr_in == 4'h3 |=> (pullup_en_out & ~$past(wdata_in)) == 8'h00; endproperty
  a_pu_mask: assert property (p_pu_mask) else $error("pull-up outside its mask");
  property p_oe_dir; wr_in && addr_in == 4'h2 |=> pin_oe_out == ~$past(wdata_in); endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("driver enable not the inverse of direction");
  property p_latch; wr_in && addr_in <= 4'h1 |=> pin_out == $past(wdata_in); endproperty
  a_latch: assert property (p_latch) else $error("latch write not on the pins");
  property p_rd_latch; rd_in && addr_in == 4'h1 |=> rdata_out == $past(pin_out); endproperty
  a_rd_latch: assert property (p_rd_latch) else $error("latch read not the latched value");
  property p_rd_pins; rd_in && addr_in == 4'h0 |=> ((rdata_out ^ $past(pin_in)) & 8'he0) == 8'h00; endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("upper pin read differs from pins");
  property p_wake; wake_out == change_irq_out; endproperty
  a_wake: assert property (p_wake) else $error("wake differs from change request");
  property p_irq_hold; change_irq_out && !(wr_in && addr_in == 4'h5) |=> change_irq_out; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("change request dropped without a control write");
  property p_gbl_off; wr_in && addr_in == 4'h5 && !wdata_in[3] |=> !change_irq_out; endproperty
  a_gbl_off: assert property (p_gbl_off) else $error("change request with global enable clear");
  c_irq: cover property (change_irq_out);
  c_pin_read: cover property (rd_in && addr_in == 4'h0);
  c_pullup: cover property (pullup_en_out != 8'h00);
endmodule
bind gpio_port gpio_port_props u_gpio_port_props (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .pin_in(pin_in), .rdata_out(rdata_out), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .pullup_en_out(pullup_en_out), .change_irq_out(change_irq_out), .wake_out(wake_out));

// *** test/pin_partner.sv ***
// Far-side pin model: resolves each pin from port driver, external source and pull-up.
// A released pin with neither external source nor pull-up shows the inverse of its last level, never a stale copy.
`timescale 1ns/1ps
module pin_partner (
  input  wire       clk_in,
  input  wire [7:0] drv_in,
  input  wire [7:0] oe_in,
  input  wire [7:0] pu_in,
  input  wire [7:0] ext_in,
  input  wire [7:0] ext_en_in,
  output wire [7:0] lvl_out
);
  reg [7:0] last_q = 8'h00;
  // Port driver wins, then external source, then pull-up
  assign lvl_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in)
                 | (~oe_in & ~ext_en_in & (pu_in | ~last_q));
  always @(posedge clk_in) begin
    last_q <= lvl_out;
  end
endmodule

// *** test/gpio_port_tb.sv ***
// Self-checking bench for the GPIO port: register tasks and pin scenarios.
// Pins come from the partner model; the strap selects analog start-up.
`timescale 1ns/1ps
module gpio_port_tb;
  reg        clk_in = 0, rst_n_in = 0, por_n_in = 0, mv = 0, wr_in = 0, rd_in = 0, strap = 1;
  reg  [3:0] addr_in = 4'h0;
  reg  [7:0] wdata_in = 8'h00, ext_val = 8'ha5, ext_en = 8'hff;
  wire [7:0] rdata_out, pin_out, pin_oe_out, pullup_en_out, pin_lvl;
  wire       change_irq_out, wake_out;
  integer    bad_count = 0, cmp_count = 0;
  always #4 clk_in = ~clk_in;
  gpio_port u_gpio_port (.clk_in(clk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in), .analog_default_cfg_in(strap),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .mem_to_mem_move_in(mv),
    .rdata_out(rdata_out), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .pullup_en_out(pullup_en_out), .change_irq_out(change_irq_out), .wake_out(wake_out));
  pin_partner u_pin_partner (.clk_in(clk_in), .drv_in(pin_out), .oe_in(pin_oe_out), .pu_in(pullup_en_out),
    .ext_in(ext_val), .ext_en_in(ext_en), .lvl_out(pin_lvl));
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
    end
  endtask
  task rd(input [3:0] a, input [7:0] e, input m = 1'b0);
    begin
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      mv <= m;
      @(posedge clk_in);
      rd_in <= 1'b0;
      mv <= 1'b0;
      #1 chk("rdata", rdata_out, e);
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge clk_in);
      #1;
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #20000;
    bad_count = bad_count + 1;
    summarize;
  end
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_n_in <= 1'b1;
    rd(4'h2, 8'hff);
    rd(4'h1, 8'h00);
    chk("pullup", pullup_en_out, 8'h00);
    rd(4'h0, 8'ha0);
    rd(4'h9, 8'h00);
    $display("test reset values done");
    wr(4'h1, 8'h3c);
    wr(4'h2, 8'h0f);
    wr(4'h7, 8'h00);
    chk("oe", pin_oe_out, 8'hf0);
    chk("out", pin_out, 8'h3c);
    rd(4'h1, 8'h3c);
    rd(4'h0, 8'h35);
    $display("test direction and latch done");
    wr(4'h2, 8'hff);
    wr(4'h3, 8'hf0);
    chk("pullup", pullup_en_out, 8'h00);
    wr(4'h6, 8'h00);
    chk("pullup", pullup_en_out, 8'hf0);
    ext_en <= 8'h0f;
    rd(4'h0, 8'hf5);
    wr(4'h2, 8'h3f);
    chk("pullup", pullup_en_out, 8'h30);
    ext_en <= 8'hff;
    $display("test pull-ups done");
    wr(4'h2, 8'hff);
    wr(4'h4, 8'hf0);
    wr(4'h5, 8'h08);
    rd(4'h0, 8'ha5);
    wr(4'h5, 8'h08);
    chk("irq", change_irq_out, 1'b0);
    wr(4'h2, 8'h7f);
    settle;
    chk("irq", change_irq_out, 1'b0);
    wr(4'h2, 8'hff);
    ext_val <= 8'h25;
    settle;
    chk("irq", change_irq_out, 1'b1);
    wr(4'h5, 8'h08);
    chk("irq", change_irq_out, 1'b1);
    rd(4'h0, 8'h25, 1'b1);
    wr(4'h5, 8'h08);
    chk("irq", change_irq_out, 1'b1);
    rd(4'h0, 8'h25);
    wr(4'h5, 8'h08);
    chk("irq", change_irq_out, 1'b0);
    ext_val <= 8'ha5;
    settle;
    wr(4'h5, 8'h01);
    chk("irq", change_irq_out, 1'b0);
    rd(4'h0, 8'ha5);
    ext_val <= 8'h05;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk("pullup", pullup_en_out, 8'h00);
    rst_n_in <= 1'b1;
    wr(4'h4, 8'hf0);
    wr(4'h5, 8'h08);
    settle;
    chk("irq", change_irq_out, 1'b1);
    $display("test change interrupt done");
    strap <= 1'b0;
    rst_n_in <= 1'b0;
    por_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_n_in <= 1'b1;
    rd(4'h0, 8'h05);
    $display("test strap done");
    summarize;
  end
endmodule
